// ---- verilog/sct_pkg.sv ----
// Shared types and timing constants for the command timing engine.
package sct_pkg;

   localparam int CLK_PS = 25000;
   localparam int CNT_W = 12;
   localparam int WS_DEPTH = 40;

   // Row operation times in picoseconds, refresh intervals in nanoseconds; plain defaults for the speed grade in use.
   localparam int T_RP_PS = 13500;
   localparam int T_RAS_PS = 35000;
   localparam int T_RFC_PS = 160000;
   localparam int T_REFI_NORM_NS = 7800;
   localparam int T_REFI_EXT_NS = 3900;
   localparam int REF_GAP_MULT = 9;

   function automatic int ru_cyc(input int ps);
      int c;
      c = (ps + CLK_PS - 1) / CLK_PS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam logic [CNT_W-1:0] T_RP_CYC = CNT_W'(ru_cyc(T_RP_PS));
   localparam logic [CNT_W-1:0] T_RAS_CYC = CNT_W'(ru_cyc(T_RAS_PS));
   localparam logic [CNT_W-1:0] T_RFC_CYC = CNT_W'(ru_cyc(T_RFC_PS));
   // A longest interval rounds down.
   localparam logic [CNT_W-1:0] REF_GAP_NORM_CYC =
      CNT_W'(REF_GAP_MULT * ((T_REFI_NORM_NS * 1000) / CLK_PS));
   localparam logic [CNT_W-1:0] REF_GAP_EXT_CYC =
      CNT_W'(REF_GAP_MULT * ((T_REFI_EXT_NS * 1000) / CLK_PS));

   localparam logic [CNT_W-1:0] ZQCS_CYC = 12'h040;
   localparam logic [3:0] ODTH4_CYC = 4'h4;
   localparam logic [3:0] ODTH8_CYC = 4'h6;
   localparam logic [5:0] WS_BL8_EXTRA = 6'h04;
   localparam logic [5:0] WS_BC4_EXTRA = 6'h02;

   typedef enum logic [3:0] {
      CMD_NOP, CMD_ACT, CMD_PRE, CMD_REF, CMD_WR, CMD_WRA, CMD_RD, CMD_ZQCS, CMD_MRS
   } sct_cmd_kind_t;

   typedef enum logic [1:0] {BM_BL8, BM_BC4, BM_OTF} sct_burst_t;

   typedef struct packed {
      sct_cmd_kind_t kind;
      logic bc4;
   } sct_cmd_t;

   typedef struct packed {
      logic [4:0] wl;
      logic [4:0] wr;
      sct_burst_t burst;
      logic dll_frozen_pd;
      logic ext_temp;
   } sct_cfg_t;

endpackage

// ---- verilog/sct_timer.sv ----
// Down-counter that holds an operation busy for a loaded number of cycles.
`timescale 1ns/100ps
module sct_timer
   import sct_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic load,
   input wire logic [CNT_W-1:0] load_val,
   output logic busy,
   output logic last
);

   logic [CNT_W-1:0] cnt;

   // A new load never shortens an operation already running.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cnt <= '0;
      end else if (load && load_val > cnt) begin
         cnt <= load_val;
      end else if (cnt != '0) begin
         cnt <= cnt - 1'b1;
      end
   end

   assign busy = (cnt != '0);
   assign last = (cnt == CNT_W'(1));

endmodule

// ---- verilog/sct_core.sv ----
// Device-side command timing engine: write start, power-down, ODT mode, ZQ and checks.
`timescale 1ns/100ps

module sct_core
   import sct_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire sct_cmd_t cmd,
   input wire sct_cfg_t cfg,
   input wire logic cke,
   input wire logic odt,
   output logic wr_start,
   output logic row_active,
   output logic pd_low_current,
   output logic odt_async_mode,
   output logic zq_active,
   output logic zq_done,
   output logic timing_violation
);

   typedef enum {PS_ACTIVE, PS_PEND, PS_LOW} sct_pd_state_t;

   sct_pd_state_t pd_state;
   sct_pd_state_t next_pd_state;
   logic row_busy;
   logic row_load;
   logic [CNT_W-1:0] row_val;
   logic zq_busy;
   logic zq_last;
   logic zq_load;
   logic is_wr;
   logic wr_bl8;
   logic [5:0] ws_delay;
   logic [WS_DEPTH-1:0] ws_pend;
   logic [WS_DEPTH-1:0] ws_bit;
   logic bank_open;
   logic odt_q;
   logic odt_fall;
   logic [3:0] odt_cnt;
   logic [3:0] odt_need;
   logic ref_armed;
   logic [CNT_W-1:0] ref_gap;
   logic [CNT_W-1:0] gap_limit;

   assign is_wr = (cmd.kind == CMD_WR) || (cmd.kind == CMD_WRA);
   assign wr_bl8 = (cfg.burst == BM_BL8) || ((cfg.burst == BM_OTF) && !cmd.bc4);

   // Only a burst chop fixed in the mode register shortens the start delay.
   assign ws_delay = 6'(cfg.wl) + ((cfg.burst == BM_BC4) ? WS_BC4_EXTRA : WS_BL8_EXTRA);
   assign ws_bit = WS_DEPTH'(1) << (ws_delay - 6'h01);

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ws_pend <= '0;
         wr_start <= 1'b0;
      end else begin
         ws_pend <= (ws_pend >> 1) | (is_wr ? ws_bit : '0);
         wr_start <= ws_pend[0];
      end
   end

   // Row operations load the busy timer with rounded-up cycle counts.
   always_comb begin
      row_load = 1'b1;
      row_val = '0;
      unique case (cmd.kind)
         CMD_ACT: row_val = T_RAS_CYC;
         CMD_PRE: row_val = T_RP_CYC;
         CMD_REF: row_val = T_RFC_CYC;
         // Auto-precharge follows the data and the MR0 write recovery in cycles.
         CMD_WRA: row_val = CNT_W'(ws_delay) + CNT_W'(cfg.wr) + T_RP_CYC;
         default: row_load = 1'b0;
      endcase
   end

   sct_timer u_row_timer (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .load(row_load),
      .load_val(row_val),
      .busy(row_busy),
      .last()
   );

   assign zq_load = (cmd.kind == CMD_ZQCS);

   sct_timer u_zq_timer (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .load(zq_load),
      .load_val(ZQCS_CYC),
      .busy(zq_busy),
      .last(zq_last)
   );

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         zq_active <= 1'b0;
         zq_done <= 1'b0;
      end else begin
         zq_active <= zq_busy;
         zq_done <= zq_last && !zq_load;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         bank_open <= 1'b0;
         row_active <= 1'b0;
      end else begin
         if (cmd.kind == CMD_ACT) begin
            bank_open <= 1'b1;
         end else if (cmd.kind == CMD_PRE || cmd.kind == CMD_WRA) begin
            bank_open <= 1'b0;
         end
         row_active <= row_busy;
      end
   end

   // CKE may fall mid-operation; the reduced current waits for the operation.
   always_comb begin
      next_pd_state = pd_state;
      unique case (pd_state)
         PS_ACTIVE: begin
            if (!cke) begin
               next_pd_state = row_busy ? PS_PEND : PS_LOW;
            end
         end
         PS_PEND: begin
            if (cke) begin
               next_pd_state = PS_ACTIVE;
            end else if (!row_busy) begin
               next_pd_state = PS_LOW;
            end
         end
         PS_LOW: begin
            if (cke) begin
               next_pd_state = PS_ACTIVE;
            end else if (row_busy) begin
               // An operation started in power-down takes the reduced current back.
               next_pd_state = PS_PEND;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pd_state <= PS_ACTIVE;
         pd_low_current <= 1'b0;
         odt_async_mode <= 1'b0;
      end else begin
         pd_state <= next_pd_state;
         pd_low_current <= (next_pd_state == PS_LOW);
         // Latency-based ODT needs a running DLL, so frozen power-down with no bank open goes asynchronous.
         odt_async_mode <= !cke && cfg.dll_frozen_pd && !bank_open;
      end
   end

   // ODT high time, counted from first sampled high to sampled low.
   assign odt_fall = odt_q && !odt;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         odt_q <= 1'b0;
         odt_cnt <= '0;
         odt_need <= '0;
      end else begin
         odt_q <= odt;
         if (odt && !odt_q) begin
            odt_cnt <= 4'h1;
            odt_need <= (is_wr && wr_bl8) ? ODTH8_CYC : ODTH4_CYC;
         end else if (odt && odt_cnt != 4'hf) begin
            odt_cnt <= odt_cnt + 4'h1;
         end
      end
   end

   assign gap_limit = cfg.ext_temp ? REF_GAP_EXT_CYC : REF_GAP_NORM_CYC;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ref_armed <= 1'b0;
         ref_gap <= '0;
      end else if (cmd.kind == CMD_REF) begin
         ref_armed <= 1'b1;
         ref_gap <= '0;
      end else if (ref_armed && ref_gap != '1) begin
         ref_gap <= ref_gap + 1'b1;
      end
   end

   // Once broken, timing stays suspect until the part is reset and re-initialised.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         timing_violation <= 1'b0;
      end else if ((odt_fall && odt_cnt < odt_need) ||
                   (ref_armed && ref_gap >= gap_limit)) begin
         timing_violation <= 1'b1;
      end
   end

   // Checks.
   localparam int RP_WAIT = ru_cyc(T_RP_PS);

   logic [5:0] probe_cnt;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         probe_cnt <= '0;
      end else if (probe_cnt == '0 && is_wr) begin
         probe_cnt <= ws_delay;
      end else if (probe_cnt != '0) begin
         probe_cnt <= probe_cnt - 6'h01;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   sequence zq_run;
      ##2 zq_active ##63 zq_done;
   endsequence

   sequence pre_run;
      ##RP_WAIT row_busy ##1 !row_busy;
   endsequence

   chk_write_start: assert property (probe_cnt == 6'h01 |=> wr_start)
      else $error("internal write start not at write latency plus burst offset");
   chk_pd_wait: assert property (pd_low_current |-> !$past(row_busy))
      else $error("low power entered while a row operation ran");
   chk_pd_enter: assert property ((pd_state == PS_PEND && !row_busy && !cke) |=> pd_low_current)
      else $error("low power not entered after operation finished");
   chk_odt_async: assert property ((!cke && cfg.dll_frozen_pd && !bank_open) |=> odt_async_mode)
      else $error("asynchronous termination not selected in frozen power-down");
   chk_zq_length: assert property ((zq_load && !zq_busy) |-> zq_run)
      else $error("short calibration did not end after 64 cycles");
   chk_row_precharge: assert property ((cmd.kind == CMD_PRE && !row_busy) |-> pre_run)
      else $error("precharge busy time differs from rounded-up cycles");
   chk_odt_short: assert property ((odt_fall && odt_cnt < odt_need) |=> timing_violation)
      else $error("short termination high time not flagged");
   chk_refresh_gap: assert property ((ref_armed && ref_gap >= gap_limit) |=> timing_violation)
      else $error("overlong refresh gap not flagged");

endmodule

// ---- dv/sct_ctrl_model.sv ----
// Controller stand-in driving commands, clock enable and termination.
`timescale 1ns/100ps
module sct_ctrl_model
   import sct_pkg::*;
(
   input wire logic sys_clk,
   output sct_cmd_t cmd,
   output logic cke,
   output logic odt
);
   localparam int XPDLL_CYC = 10;
   initial begin
      cmd = '{kind: CMD_NOP, bc4: 1'b0};
      cke = 1'b1;
      odt = 1'b0;
   end
   // Spacing is counted in received edges, never in elapsed time.
   task automatic issue(input sct_cmd_kind_t k, input logic b);
      @(negedge sys_clk);
      // Reads are never issued, so no mode register set can follow a read burst too soon.
      cmd <= '{kind: k, bc4: b};
      @(negedge sys_clk);
      cmd <= '{kind: CMD_NOP, bc4: 1'b0};
   endtask
   // Leaving power-down, the longer exit delay is kept ahead of every later command.
   task automatic set_cke(input logic v);
      @(negedge sys_clk);
      cke <= v;
      if (v) begin
         repeat (XPDLL_CYC) @(negedge sys_clk);
      end
   endtask
   // A hold below the minimum is only used where a violation is wanted.
   task automatic odt_hold(input int n, input logic wr);
      @(negedge sys_clk);
      odt <= 1'b1;
      if (wr) begin
         cmd <= '{kind: CMD_WR, bc4: 1'b0};
      end
      repeat (n) begin
         @(negedge sys_clk);
         cmd <= '{kind: CMD_NOP, bc4: 1'b0};
      end
      odt <= 1'b0;
   endtask
endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench for the command timing engine.
`timescale 1ns/100ps
module tb_top
   import sct_pkg::*;
;
   logic sys_clk;
   logic sys_rst;
   sct_cfg_t cfg;
   sct_cmd_t cmd;
   logic cke, odt, wr_start, row_active, pd_low_current, odt_async_mode;
   logic zq_active, zq_done, timing_violation;
   int num_errors = 0;
   int checks = 0;
   int k;
   int n;
   sct_ctrl_model u_sct_ctrl_model (.sys_clk(sys_clk), .cmd(cmd), .cke(cke), .odt(odt));
   sct_core u_sct_core (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd(cmd), .cfg(cfg),
      .cke(cke), .odt(odt), .wr_start(wr_start), .row_active(row_active),
      .pd_low_current(pd_low_current), .odt_async_mode(odt_async_mode),
      .zq_active(zq_active), .zq_done(zq_done), .timing_violation(timing_violation));
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic do_reset();
      sys_rst <= 1'b1;
      repeat (10) @(negedge sys_clk);
      sys_rst <= 1'b0;
   endtask
   function automatic int ru(input int ps);
      return (ps + CLK_PS - 1) / CLK_PS;
   endfunction
   task automatic write_case(input logic [4:0] wl, input sct_burst_t b, input logic c);
      cfg.wl = wl;
      cfg.burst = b;
      u_sct_ctrl_model.issue(CMD_WR, c);
      k = 0;
      while (wr_start !== 1'b1 && k < 60) begin
         @(negedge sys_clk);
         k++;
      end
      chk(12'(k), 12'(int'(wl) + ((b == BM_BC4) ? 2 : 4)));
   endtask
   // Counts the cycles a row operation keeps the row timer busy.
   task automatic row_case(input sct_cmd_kind_t kd, input int exp);
      u_sct_ctrl_model.issue(kd, 1'b0);
      k = 0;
      repeat (60) begin
         @(negedge sys_clk);
         k += int'(row_active === 1'b1);
      end
      chk(12'(k), 12'(exp));
   endtask
   initial begin
      cfg = '0;
      sys_rst = 1'b1;
      void'($urandom(32'h8e7d));
      do_reset();
      chk({5'h00, wr_start, row_active, pd_low_current, odt_async_mode, zq_active,
         zq_done, timing_violation}, 12'h000);
      for (int i = 0; i < 9; i++) begin
         n = (i < 3) ? 31 : $urandom_range(31, 0);
         write_case(5'(n), sct_burst_t'(i % 3), 1'((i / 3) % 2));
      end
      cfg.burst = BM_BL8;
      cfg.wl = 5'h05;
      cfg.wr = 5'($urandom_range(16, 5));
      row_case(CMD_WRA, int'(cfg.wl) + 4 + int'(cfg.wr) + ru(T_RP_PS));
      row_case(CMD_PRE, ru(T_RP_PS));
      row_case(CMD_ACT, ru(T_RAS_PS));
      row_case(CMD_REF, ru(T_RFC_PS));
      u_sct_ctrl_model.issue(CMD_ZQCS, 1'b0);
      k = 0;
      n = 0;
      for (int i = 1; i <= 80; i++) begin
         @(negedge sys_clk);
         k += int'(zq_active === 1'b1);
         if (zq_done === 1'b1) begin
            n = i;
         end
      end
      chk(12'(k), 12'h040);
      chk(12'(n), 12'h040);
      cfg.dll_frozen_pd = 1'b1;
      u_sct_ctrl_model.issue(CMD_ACT, 1'b0);
      u_sct_ctrl_model.issue(CMD_REF, 1'b0);
      u_sct_ctrl_model.set_cke(1'b0);
      k = 0;
      repeat (14) begin
         @(negedge sys_clk);
         k += int'(pd_low_current === 1'b1 && row_active === 1'b1);
      end
      chk(12'(k), 12'h000);
      chk({11'h000, pd_low_current}, 12'h001);
      chk({11'h000, odt_async_mode}, 12'h000);
      u_sct_ctrl_model.issue(CMD_PRE, 1'b0);
      repeat (4) @(negedge sys_clk);
      chk({11'h000, odt_async_mode}, 12'h001);
      u_sct_ctrl_model.set_cke(1'b1);
      repeat (3) @(negedge sys_clk);
      chk({10'h000, pd_low_current, odt_async_mode}, 12'h000);
      // Each hold is judged from a fresh reset, since the flag never clears itself.
      for (int i = 0; i < 4; i++) begin
         do_reset();
         n = int'((i / 2) ? ODTH8_CYC : ODTH4_CYC) - 1 + (i % 2);
         u_sct_ctrl_model.odt_hold(n, 1'(i / 2));
         repeat (3) @(negedge sys_clk);
         chk({11'h000, timing_violation}, 12'(1 - (i % 2)));
      end
      do_reset();
      cfg.ext_temp = 1'b1;
      u_sct_ctrl_model.issue(CMD_REF, 1'b0);
      repeat (int'(REF_GAP_EXT_CYC) - 2) @(negedge sys_clk);
      u_sct_ctrl_model.issue(CMD_REF, 1'b0);
      repeat (3) @(negedge sys_clk);
      chk({11'h000, timing_violation}, 12'h000);
      repeat (int'(REF_GAP_EXT_CYC) - 4) @(negedge sys_clk);
      u_sct_ctrl_model.issue(CMD_REF, 1'b0);
      repeat (3) @(negedge sys_clk);
      chk({11'h000, timing_violation}, 12'h001);
      summarize();
   end
   initial begin
      #(25 * 20000);
      num_errors++;
      summarize();
   end
endmodule
